// file: hdl/pat_defs.svh
/*
 * Constants of the PWM auto-reload timer: register offsets, field
 * positions, reset values and counter limits.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef PAT_DEFS_SVH
`define PAT_DEFS_SVH

// register offsets on the plain register port
`define PAT_ADDR_CSR   3'h0
`define PAT_ADDR_CAR   3'h1
`define PAT_ADDR_ARR   3'h2
`define PAT_ADDR_PWMC  3'h3
`define PAT_ADDR_DUTY0 3'h4
`define PAT_ADDR_DUTY1 3'h5
`define PAT_ADDR_DUTY2 3'h6
`define PAT_ADDR_DUTY3 3'h7

// timer_control_status fields
`define PAT_CSR_EXT    7
`define PAT_CSR_DIV_HI 6
`define PAT_CSR_DIV_LO 4
`define PAT_CSR_RUN    3
`define PAT_CSR_FORCE  2
`define PAT_CSR_OIE    1
`define PAT_CSR_OVF    0

// pwm_control fields
`define PAT_PWMC_OE_HI 7
`define PAT_PWMC_OE_LO 4
`define PAT_PWMC_OP_HI 3
`define PAT_PWMC_OP_LO 0

// reset values and counter limits
`define PAT_RST_BYTE   8'h00
`define PAT_RST_DIV    3'h0
`define PAT_RST_PRESC  7'h00
`define PAT_RST_CH     4'h0
`define PAT_CNT_MAX    8'hFF
`define PAT_CNT_STEP   8'h01
`define PAT_PRESC_STEP 7'h01
`define PAT_CHANNELS   4

`endif

// file: hdl/pat_pkg.sv
/*
 * Types of the PWM auto-reload timer.
 * Assumes pat_defs.svh is on the include path.
 */
`include "pat_defs.svh"

package pat_pkg;

  typedef logic [7:0] pat_byte_type;

  typedef enum logic [2:0] {
    PAT_REG_CSR   = `PAT_ADDR_CSR,
    PAT_REG_CAR   = `PAT_ADDR_CAR,
    PAT_REG_ARR   = `PAT_ADDR_ARR,
    PAT_REG_PWMC  = `PAT_ADDR_PWMC,
    PAT_REG_DUTY0 = `PAT_ADDR_DUTY0,
    PAT_REG_DUTY1 = `PAT_ADDR_DUTY1,
    PAT_REG_DUTY2 = `PAT_ADDR_DUTY2,
    PAT_REG_DUTY3 = `PAT_ADDR_DUTY3
  } pat_reg_type;

endpackage

// file: hdl/pat_prescaler.sv
/*
 * 7-bit power-of-two prescaler with eight taps.
 * Assumes in_tick marks one input clock period of the selected source
 * and that clear and run come from the timer's control logic.
 */
`timescale 1ns/1ps
`include "pat_defs.svh"

module pat_prescaler (
  input  wire logic       ref_clk,       // system clock
  input  wire logic       rst_n,         // synchronous reset, low
  input  wire logic       in_tick,       // one period of selected input
  input  wire logic       run,           // counting allowed
  input  wire logic       clear,         // software initialisation
  input  wire logic [2:0] div_sel,       // tap select, divide by 2^n
  output logic            tick,          // counter clock event
  output logic [6:0]      value          // prescaler state
);

  logic [6:0] mask;

  // tap n fires when the low n bits are all ones
  always_comb begin
    mask = 7'((8'h01 << div_sel) - 8'h01);
    tick = run && in_tick && ((value & mask) == mask);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      value <= `PAT_RST_PRESC;
    end else if (clear) begin
      value <= `PAT_RST_PRESC;
    end else if (run && in_tick) begin
      value <= value + `PAT_PRESC_STEP;
    end
  end

endmodule

// file: hdl/pat_timer.sv
/*
 * PWM auto-reload timer: 8-bit reloading counter, four PWM channels with
 * double-buffered compare values, register port and overflow flag.
 * Assumes a CPU-side master on the plain register port, an external
 * clock pin already synchronous to ref_clk and a halt level from the
 * power controller.
 */
// Contract
// - 8-bit counter steps by one on each prescaler output tick.
// - Counter readable and writable through the access register while running.
// - Overflow reloads counter with reload value; prescaler not touched.
// - Prescaler 7 bits, eight taps, divides by two to the select value.
// - Prescaler input is CPU clock or external clock per select bit.
// - Run-enable clear freezes prescaler and counter; set lets them count.
// - Reset clears counter, prescaler, and selects CPU clock.
// - Forced reload or counter write clears prescaler; no direct prescaler access.
// - Four hidden compare values copied from duty registers at each overflow.
// - Enabled channel pin is driven push-pull with the PWM signal.
// - All channels share period: counter clock over 256 minus reload.
// - At overflow each pin goes to the level chosen by its polarity.
// - On reaching compare value the pin returns to its other level; code flips it only once the counter passes compare.
// - PWM generation stops during halt.
// - Timer interrupt events can wake the system from wait and halt.
// - Overflow sets flag, interrupts if enabled; status read clears flag.
// - Polarity 0: high while counter at or below compare; 1 inverts at once.
// - Force-reload bit acts on write only and reads zero.
// - Select 0 routes CPU clock, select 1 routes external clock.
`timescale 1ns/1ps
`include "pat_defs.svh"

module pat_timer (
  input  wire logic       ref_clk,       // CPU clock, 50 MHz
  input  wire logic       rst_n,         // synchronous reset, low
  input  wire logic [2:0] reg_addr,      // register offset
  input  wire logic [7:0] reg_wdata,     // write data
  input  wire logic       reg_wr,        // write strobe
  input  wire logic       reg_rd,        // read strobe
  output logic      [7:0] reg_rdata,     // read data, cycle after strobe
  input  wire logic       ext_clk_in,    // external prescaler clock
  input  wire logic       halt_mode,     // system in halt
  output logic      [3:0] pwm_output_pin, // PWM levels
  output logic      [3:0] pwm_pin_oe,    // pin driven by timer
  output logic            overflow_irq   // overflow request, also wake
);

  ////////////////////////////////////////////////////////////////////////
  // register state

  logic                 external_clock_select;
  logic [2:0]           counter_divider_select;
  logic                 counter_run_enable;
  logic                 overflow_interrupt_enable;
  logic                 overflow_flag;
  pat_pkg::pat_byte_type auto_reload_value;
  pat_pkg::pat_byte_type counter;
  pat_pkg::pat_byte_type pwm_control;
  pat_pkg::pat_byte_type duty_cycle_value [`PAT_CHANNELS];
  pat_pkg::pat_byte_type compare_value [`PAT_CHANNELS];
  logic                 ext_prev;

  ////////////////////////////////////////////////////////////////////////
  // decode

  pat_pkg::pat_reg_type  reg_sel;
  logic                 csr_wr;
  logic                 csr_rd;
  logic                 car_wr;
  logic                 force_wr;
  logic                 duty_wr;
  logic                 sw_load;

  always_comb begin
    reg_sel  = pat_pkg::pat_reg_type'(reg_addr);
    csr_wr   = reg_wr && (reg_sel == pat_pkg::PAT_REG_CSR);
    csr_rd   = reg_rd && (reg_sel == pat_pkg::PAT_REG_CSR);
    car_wr   = reg_wr && (reg_sel == pat_pkg::PAT_REG_CAR);
    force_wr = csr_wr && reg_wdata[`PAT_CSR_FORCE];
    duty_wr  = reg_wr && reg_addr[2];
    sw_load  = car_wr || force_wr;
  end

  ////////////////////////////////////////////////////////////////////////
  // control register writes

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      external_clock_select     <= 1'b0;
      counter_divider_select    <= `PAT_RST_DIV;
      counter_run_enable        <= 1'b0;
      overflow_interrupt_enable <= 1'b0;
    end else if (csr_wr) begin
      external_clock_select     <= reg_wdata[`PAT_CSR_EXT];
      counter_divider_select    <= reg_wdata[`PAT_CSR_DIV_HI:`PAT_CSR_DIV_LO];
      counter_run_enable        <= reg_wdata[`PAT_CSR_RUN];
      overflow_interrupt_enable <= reg_wdata[`PAT_CSR_OIE];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      auto_reload_value <= `PAT_RST_BYTE;
    end else if (reg_wr && (reg_sel == pat_pkg::PAT_REG_ARR)) begin
      auto_reload_value <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pwm_control <= `PAT_RST_BYTE;
    end else if (reg_wr && (reg_sel == pat_pkg::PAT_REG_PWMC)) begin
      pwm_control <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < `PAT_CHANNELS; i++) begin
        duty_cycle_value[i] <= `PAT_RST_BYTE;
      end
    end else if (duty_wr) begin
      duty_cycle_value[reg_addr[1:0]] <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input clock selection and prescaler

  logic       ext_edge;
  logic       in_tick;
  logic       run_eff;
  logic       cnt_tick;
  logic [6:0] presc_value;

  // pin is already synchronous, so one stage suffices for the edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_clk_in;
    end
  end

  always_comb begin
    ext_edge = ext_clk_in && !ext_prev;
    in_tick  = external_clock_select ? ext_edge : 1'b1;
    // halt freezes counting; the external clock is not usable there
    run_eff  = counter_run_enable && !halt_mode;
  end

  pat_prescaler u_prescaler (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .in_tick (in_tick),
    .run     (run_eff),
    .clear   (sw_load),
    .div_sel (counter_divider_select),
    .tick    (cnt_tick),
    .value   (presc_value)
  );

  ////////////////////////////////////////////////////////////////////////
  // counter, reload and overflow

  logic overflow_event;

  // a software load wins over a tick in the same cycle
  always_comb begin
    overflow_event = cnt_tick && (counter == `PAT_CNT_MAX) && !sw_load;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      counter <= `PAT_RST_BYTE;
    end else if (car_wr) begin
      counter <= reg_wdata;
    end else if (force_wr) begin
      counter <= auto_reload_value;
    end else if (overflow_event) begin
      counter <= auto_reload_value;
    end else if (cnt_tick) begin
      counter <= counter + `PAT_CNT_STEP;
    end
  end

  // set wins over the clearing read
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      overflow_flag <= 1'b0;
    end else if (overflow_event) begin
      overflow_flag <= 1'b1;
    end else if (csr_rd) begin
      overflow_flag <= 1'b0;
    end
  end

  // level request doubles as wake source from wait and halt
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      overflow_irq <= 1'b0;
    end else begin
      overflow_irq <= overflow_flag && overflow_interrupt_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port

  pat_pkg::pat_byte_type rd_mux;

  always_comb begin
    case (reg_sel)
      pat_pkg::PAT_REG_CSR: begin
        rd_mux = {external_clock_select, counter_divider_select,
                  counter_run_enable, 1'b0,
                  overflow_interrupt_enable, overflow_flag};
      end
      pat_pkg::PAT_REG_CAR: begin
        rd_mux = counter;
      end
      pat_pkg::PAT_REG_ARR: begin
        rd_mux = auto_reload_value;
      end
      pat_pkg::PAT_REG_PWMC: begin
        rd_mux = pwm_control;
      end
      default: begin
        rd_mux = duty_cycle_value[reg_addr[1:0]];
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= `PAT_RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= `PAT_RST_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // PWM channels

  logic [3:0] ch_enable;
  logic [3:0] ch_polarity;
  logic [3:0] ch_level;

  always_comb begin
    ch_enable   = pwm_control[`PAT_PWMC_OE_HI:`PAT_PWMC_OE_LO];
    ch_polarity = pwm_control[`PAT_PWMC_OP_HI:`PAT_PWMC_OP_LO];
  end

  genvar ch;
  generate
    for (ch = 0; ch < `PAT_CHANNELS; ch++) begin : g_ch
      // hidden compare copy avoids glitches on live duty changes
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          compare_value[ch] <= `PAT_RST_BYTE;
        end else if (overflow_event) begin
          compare_value[ch] <= duty_cycle_value[ch];
        end
      end

      // reload value lands at or below compare: level set at overflow,
      // flips once the counter passes compare
      always_comb begin
        ch_level[ch] = (counter <= compare_value[ch]) ^ ch_polarity[ch];
      end

      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          pwm_output_pin[ch] <= 1'b0;
          pwm_pin_oe[ch]     <= 1'b0;
        end else if (halt_mode) begin
          pwm_output_pin[ch] <= pwm_output_pin[ch];
          pwm_pin_oe[ch]     <= ch_enable[ch];
        end else begin
          pwm_output_pin[ch] <= ch_enable[ch] && ch_level[ch];
          pwm_pin_oe[ch]     <= ch_enable[ch];
        end
      end

      AST_PWM_LEVEL: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !halt_mode |=> pwm_output_pin[ch] == ($past(ch_enable[ch]) && $past(ch_level[ch])))
        else $error("pwm pin does not follow counter against compare");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_plain_tick;
    cnt_tick && !sw_load && (counter != `PAT_CNT_MAX);
  endsequence

  sequence seq_overflow;
    overflow_event;
  endsequence

  sequence seq_force;
    force_wr && !car_wr;
  endsequence

  AST_COUNT_STEP: assert property (
    seq_plain_tick |=> counter == 8'($past(counter) + `PAT_CNT_STEP))
    else $error("counter did not step by one");

  AST_CAR_WRITE: assert property (
    car_wr |=> (counter == $past(reg_wdata)) && (presc_value == `PAT_RST_PRESC))
    else $error("counter write not taken");

  AST_RELOAD: assert property (
    seq_overflow |=> (counter == $past(auto_reload_value)) && overflow_flag)
    else $error("overflow did not reload or flag");

  AST_FREEZE: assert property (
    (!run_eff && !sw_load) |=> $stable(counter) && $stable(presc_value))
    else $error("counter moved while stopped");

  AST_FORCE: assert property (
    seq_force |=> (counter == $past(auto_reload_value)) && (presc_value == `PAT_RST_PRESC))
    else $error("forced reload failed");

  AST_CMP_LOAD: assert property (
    seq_overflow |=> compare_value[0] == $past(duty_cycle_value[0])
                 ##0 compare_value[3] == $past(duty_cycle_value[3]))
    else $error("compare copy missing at overflow");

  // only a status read shows the force bit; other registers use bit 2 freely
  AST_FORCE_READ: assert property (
    csr_rd |=> !reg_rdata[`PAT_CSR_FORCE])
    else $error("force bit read back as one");

  AST_OVF_CLEAR: assert property (
    (csr_rd && !overflow_event) |=> !overflow_flag ##1 !overflow_irq)
    else $error("status read did not clear overflow");

  AST_IRQ: assert property (
    (overflow_event && overflow_interrupt_enable && !csr_wr) |=> ##1 overflow_irq)
    else $error("overflow request missing");

  AST_HALT: assert property (
    (halt_mode && !sw_load) [*2] |-> $stable(counter) && $stable(pwm_output_pin))
    else $error("timer ran during halt");

  AST_CPU_TAP: assert property (
    (run_eff && !external_clock_select && (counter_divider_select == 3'h0) && !sw_load)
      |-> cnt_tick)
    else $error("undivided CPU clock gave no tick");

endmodule

// file: sim/pat_load_model.sv
/*
 * Load model on the four PWM pins: resolves each pad from the timer's
 * level and output enable.
 * Assumes the pins are sampled on ref_clk and no pull resistor is fitted.
 */
`timescale 1ns/1ps

module pat_load_model (
  input  wire logic       ref_clk,        // system clock
  input  wire logic       rst_n,          // synchronous reset, low
  input  wire logic [3:0] pwm_output_pin, // timer levels
  input  wire logic [3:0] pwm_pin_oe,     // timer drives the pad
  output logic      [3:0] pad             // level seen by the load
);
  logic [3:0] last_level;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) last_level <= 4'h0;
    else last_level <= (pwm_pin_oe & pwm_output_pin) | (~pwm_pin_oe & last_level);
  end

  // undriven pad floats: show the inverse so a stale level never passes
  always_comb begin
    pad = (pwm_pin_oe & pwm_output_pin) | (~pwm_pin_oe & ~last_level);
  end
endmodule

// file: sim/tb_pwm_auto_reload_timer.sv
/*
 * Self-checking bench of the PWM auto-reload timer.
 * Assumes the design under hdl/ and the load model in sim/.
 */
`timescale 1ns/1ps
`include "pat_defs.svh"

module tb_pwm_auto_reload_timer;
  logic       ref_clk;
  logic       rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       ext_clk_in = 1'b0;
  logic       halt_mode = 1'b0;
  logic [3:0] pwm_output_pin;
  logic [3:0] pwm_pin_oe;
  logic       overflow_irq;
  logic [3:0] pad;
  logic       ext_run = 1'b0;
  logic [2:0] ext_div = 3'h0;
  int         miscompares = 0;
  int         num_checks = 0;
  int         cycles = 0;

  pat_timer DUT (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_clk_in(ext_clk_in), .halt_mode(halt_mode), .pwm_output_pin(pwm_output_pin),
    .pwm_pin_oe(pwm_pin_oe), .overflow_irq(overflow_irq));

  pat_load_model load (.ref_clk(ref_clk), .rst_n(rst_n), .pwm_output_pin(pwm_output_pin),
    .pwm_pin_oe(pwm_pin_oe), .pad(pad));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // external source: one rising edge every 8 cycles while enabled
  always @(posedge ref_clk) begin
    if (ext_run) ext_div <= ext_div + 3'h1;
    ext_clk_in <= ext_div[2];
  end

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      end_sim();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // one strobe cycle, then one idle edge so strobes never re-assert in a step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  // data stand in the cycle after the strobe: taken at the edge closing it
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    idle(2);
    rst_n <= 1'b1;
    idle(1);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] d;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), d);
      chk("reset register", 8'h00, d);
    end
    @(posedge ref_clk);
    chk("idle rdata", 8'h00, reg_rdata);
    chk("reset pins", 8'h00, {pwm_pin_oe, pwm_output_pin});
    chk("reset irq", 8'h00, {7'h00, overflow_irq});
  endtask

  task automatic t_regs();
    logic [7:0] d;
    for (int a = 2; a < 8; a++) wr(3'(a), 8'(8'h17 * a));
    for (int a = 2; a < 8; a++) begin
      rd(3'(a), d);
      chk("readback", 8'(8'h17 * a), d);
    end
    wr(`PAT_ADDR_CSR, 8'h76);
    rd(`PAT_ADDR_CSR, d);
    chk("force reads zero", 8'h72, d);
    do_reset();
    rd(`PAT_ADDR_CSR, d);
    chk("second reset csr", 8'h00, d);
    rd(`PAT_ADDR_ARR, d);
    chk("second reset reload", 8'h00, d);
  endtask

  // counts over a window that is a whole number of prescaler periods
  task automatic t_div();
    logic [7:0] a;
    logic [7:0] b;
    wr(`PAT_ADDR_ARR, 8'h00);
    for (int n = 0; n < 8; n++) begin
      wr(`PAT_ADDR_CSR, 8'(8'h08 | (n << 4)));
      wr(`PAT_ADDR_CAR, 8'h00);
      rd(`PAT_ADDR_CAR, a);
      idle(126);
      rd(`PAT_ADDR_CAR, b);
      chk("ticks per window", 8'(128 >> n), b - a);
    end
  endtask

  // prescaler left mid-count by t_div: only a clear keeps the next tick late
  task automatic t_force();
    logic [7:0] d;
    wr(`PAT_ADDR_ARR, 8'h80);
    wr(`PAT_ADDR_CSR, 8'h7C);
    rd(`PAT_ADDR_CAR, d);
    chk("forced load", 8'h80, d);
    idle(110);
    rd(`PAT_ADDR_CAR, d);
    chk("prescaler cleared", 8'h80, d);
    idle(30);
    rd(`PAT_ADDR_CAR, d);
    chk("first tick", 8'h81, d);
  endtask

  task automatic t_pwm();
    logic [7:0] d;
    logic       prev;
    int         hi[4];
    int         rises;
    int         k;
    wr(`PAT_ADDR_ARR, 8'hF0);
    wr(`PAT_ADDR_DUTY0, 8'hF3);
    wr(`PAT_ADDR_DUTY1, 8'hF8);
    wr(`PAT_ADDR_DUTY2, 8'hFF);
    wr(`PAT_ADDR_DUTY3, 8'hF0);
    wr(`PAT_ADDR_PWMC, 8'hF2);
    wr(`PAT_ADDR_CSR, 8'h0E);
    idle(40);
    chk("output enables", 8'h0F, {4'h0, pwm_pin_oe});
    hi = '{0, 0, 0, 0};
    rises = 0;
    prev = pad[0];
    repeat (32) begin
      @(posedge ref_clk);
      for (int c = 0; c < 4; c++) hi[c] += int'(pad[c]);
      if (pad[0] && !prev) rises++;
      prev = pad[0];
    end
    chk("ch0 high", 8'h08, 8'(hi[0]));
    chk("ch1 high", 8'h0E, 8'(hi[1]));
    chk("ch2 high", 8'h20, 8'(hi[2]));
    chk("ch3 high", 8'h02, 8'(hi[3]));
    chk("periods", 8'h02, 8'(rises));
    rd(`PAT_ADDR_CSR, d);
    chk("flag before read", 8'h0B, d);
    // the request seen here is still the old one: wait for it to drop first
    for (k = 0; k < 20 && overflow_irq !== 1'b0; k++) @(posedge ref_clk);
    chk("irq dropped", 8'h00, {7'h00, overflow_irq});
    for (k = 0; k < 20 && overflow_irq !== 1'b1; k++) @(posedge ref_clk);
    chk("irq raised", 8'h01, {7'h00, overflow_irq});
    rd(`PAT_ADDR_CSR, d);
    chk("flag set", 8'h0B, d);
    @(posedge ref_clk);
    chk("irq cleared", 8'h00, {7'h00, overflow_irq});
  endtask

  // new duty must wait for an overflow, which never comes while frozen
  task automatic t_frozen();
    logic [7:0] c;
    logic [7:0] d;
    logic       lo;
    wr(`PAT_ADDR_CSR, 8'h00);
    rd(`PAT_ADDR_CAR, c);
    idle(20);
    rd(`PAT_ADDR_CAR, d);
    chk("frozen count", c, d);
    lo = c <= 8'hF3;
    wr(`PAT_ADDR_DUTY0, lo ? 8'h00 : 8'hFF);
    idle(3);
    chk("held pins", {4'h0, c <= 8'hF0, 1'b1, c > 8'hF8, lo}, {4'h0, pad});
    wr(`PAT_ADDR_PWMC, 8'hF1);
    idle(3);
    chk("polarity", {4'h0, c <= 8'hF0, 1'b1, c <= 8'hF8, !lo}, {4'h0, pad});
  endtask

  task automatic t_halt();
    logic [7:0] c;
    logic [7:0] d;
    logic [3:0] p;
    wr(`PAT_ADDR_CSR, 8'h08);
    idle(40);
    chk("masked irq", 8'h00, {7'h00, overflow_irq});
    halt_mode <= 1'b1;
    idle(2);
    p = pad;
    rd(`PAT_ADDR_CAR, c);
    idle(30);
    rd(`PAT_ADDR_CAR, d);
    chk("halt count", c, d);
    chk("halt pins", {4'h0, p}, {4'h0, pad});
    // flag left pending by the run above; enabling it must raise the wake line
    wr(`PAT_ADDR_CSR, 8'h0A);
    idle(1);
    chk("wake request in halt", 8'h01, {7'h00, overflow_irq});
    halt_mode <= 1'b0;
    idle(1);
  endtask

  task automatic t_ext();
    logic [7:0] a;
    logic [7:0] b;
    int         hi;
    wr(`PAT_ADDR_ARR, 8'h00);
    wr(`PAT_ADDR_CSR, 8'h88);
    wr(`PAT_ADDR_CAR, 8'h00);
    rd(`PAT_ADDR_CAR, a);
    idle(62);
    rd(`PAT_ADDR_CAR, b);
    chk("quiet ext source", a, b);
    ext_run <= 1'b1;
    rd(`PAT_ADDR_CAR, a);
    idle(62);
    rd(`PAT_ADDR_CAR, b);
    chk("ext edges", 8'h08, b - a);
    wr(`PAT_ADDR_CSR, 8'h08);
    rd(`PAT_ADDR_CAR, a);
    idle(62);
    rd(`PAT_ADDR_CAR, b);
    chk("cpu source", 8'h40, b - a);
    // full-resolution reload with inverted polarity gives a flat zero duty
    wr(`PAT_ADDR_DUTY0, 8'hFF);
    wr(`PAT_ADDR_PWMC, 8'h11);
    idle(258);
    hi = 0;
    repeat (255) begin
      @(posedge ref_clk);
      hi += int'(pad[0]);
    end
    chk("zero duty", 8'h00, 8'(hi));
  endtask

  initial begin
    do_reset();
    t_reset();
    t_regs();
    t_div();
    t_force();
    t_pwm();
    t_frozen();
    t_halt();
    t_ext();
    end_sim();
  end
endmodule
